/* rtl/transfer_controller_defines.svh */
// What this block does
// - Source address picks where each unit is read
// - Destination address picks where each unit is written
// - Transfer information reachable only by the controller
// - Normal mode: 16-bit counter, minus one per transfer
// - Normal count zero: clear enable, interrupt CPU
// - Count one is 1, zero is 65536
// - Repeat: reload byte high, 8-bit counter low
// - Repeat counter zero reloads from high byte
// - Repeat bytes 01/FF/00 give 1/255/256 transfers
// - Block: high byte size, low byte counts units
// - Block size zero means 256, reload at zero
// - Block count word minus one per block
// - Block count zero: clear enable, interrupt CPU
// - Second count word unused in normal, repeat
// - Five enable banks route sources to controller
// - Control bit allows skipping refetch on same vector
// - Vector base register locates vector table entries
// - Transmit-empty request moves RAM data to FIFO
// - Port drains eight bytes before next request
// - Receive-full request moves FIFO data to RAM
// - Receive end interrupts CPU; software clears enables
// - FIFOs sixteen bytes; overflow data is dropped
`ifndef TRANSFER_CONTROLLER_DEFINES_SVH
`define TRANSFER_CONTROLLER_DEFINES_SVH

// Register byte offsets and word indexes on the APB side
`define OFS_ENABLE_FIRST 8'h00
`define OFS_ENABLE_LAST 8'h10
`define OFS_CONTROL 8'h14
`define OFS_VECTOR_BASE 8'h18
`define OFS_STATUS 8'h1c
`define IDX_CONTROL 3'h5
`define IDX_VECTOR_BASE 3'h6
`define IDX_STATUS 3'h7

// Field positions
`define CTRL_SKIP_BIT 4
`define INFO_MODE_A_HI 31
`define INFO_MODE_A_LO 24
`define INFO_MODE_B_HI 23
`define INFO_MODE_B_LO 16
`define MODE_MD_HI 7
`define MODE_MD_LO 6
`define MODE_SZ_HI 5
`define MODE_SZ_LO 4
`define MODE_SM_HI 3
`define MODE_SM_LO 2
`define MODE_DM_HI 1
`define MODE_DM_LO 0

// Encodings and reset values
`define MD_NORMAL 2'h0
`define MD_REPEAT 2'h1
`define MD_BLOCK 2'h2
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2
`define AM_INC 2'h1
`define AM_DEC 2'h2
`define INFO_LAST_WORD 2'h3
`define RST_WORD 32'h0000_0000
`define RST_HALF 16'h0000

`endif

/* rtl/transfer_controller_pkg.sv */
package transfer_controller_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_VEC_RD,
        ST_INFO_RD,
        ST_DATA_RD,
        ST_DATA_WR,
        ST_WRITE_BACK
    } xfer_state_t;

endpackage

/* rtl/source_picker.sv */
`timescale 1ns/100ps
module source_picker #(
    parameter int NUM_SRC = 80,
    parameter int IDX_W = 7
) (
    input wire logic [NUM_SRC-1:0] src_req,
    input wire logic [NUM_SRC-1:0] src_en,
    output logic pick_valid,
    output logic [IDX_W-1:0] pick_idx,
    output logic [NUM_SRC-1:0] cpu_irq
);

    function automatic logic [IDX_W-1:0] lowest(input logic [NUM_SRC-1:0] v);
        logic [IDX_W-1:0] r;
        r = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = IDX_W'(i);
            end
        end
        return r;
    endfunction

    // Enabled sources wake the controller, the rest go straight to the CPU
    always_comb begin
        cpu_irq = src_req & ~src_en;
        pick_valid = |(src_req & src_en);
        pick_idx = lowest(src_req & src_en);
    end

endmodule

/* rtl/count_step.sv */
`timescale 1ns/100ps
`include "transfer_controller_defines.svh"
module count_step (
    input wire logic [1:0] mode,
    input wire logic [15:0] count_a,
    input wire logic [15:0] count_b,
    output logic [15:0] count_a_next,
    output logic [15:0] count_b_next,
    output logic unit_last,
    output logic chan_end
);

    logic [7:0] low_next;
    logic [15:0] whole_next;
    logic [15:0] blocks_next;

    always_comb begin
        whole_next = count_a - 16'h0001;
        low_next = count_a[7:0] - 8'h01;
        blocks_next = count_b - 16'h0001;
        count_a_next = count_a;
        count_b_next = count_b;
        unit_last = 1'b1;
        chan_end = 1'b0;
        unique case (mode)
            `MD_REPEAT: begin
                count_a_next = {count_a[15:8],
                                (low_next == 8'h00) ? count_a[15:8] : low_next};
            end
            `MD_BLOCK: begin
                unit_last = (low_next == 8'h00);
                count_a_next = {count_a[15:8], unit_last ? count_a[15:8] : low_next};
                if (unit_last) begin
                    count_b_next = blocks_next;
                    chan_end = (blocks_next == `RST_HALF);
                end
            end
            default: begin
                count_a_next = whole_next;
                chan_end = (whole_next == `RST_HALF);
            end
        endcase
    end

endmodule

/* rtl/transfer_controller.sv */
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "transfer_controller_defines.svh"
module transfer_controller
    import transfer_controller_pkg::*;
#(
    parameter int BANKS = 5,
    parameter int NUM_SRC = 16 * BANKS,
    parameter int IDX_W = 7
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_SRC-1:0] src_req,
    output logic [NUM_SRC-1:0] cpu_irq,
    output logic xfer_done,
    output logic mem_req,
    output logic mem_we,
    output logic [1:0] mem_size,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack
);

    ////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        xfer_state_t st;
        logic [BANKS-1:0][15:0] enable;
        logic skip_ok;
        logic [31:0] vector_base;
        logic [31:0] prdata;
        logic [IDX_W-1:0] src;
        logic [IDX_W-1:0] last_src;
        logic last_valid;
        logic [31:0] info_ptr;
        logic [7:0] mode_a;
        logic [7:0] mode_b;
        logic [15:0] count_a;
        logic [31:0] src_addr;
        logic [31:0] dst_addr;
        logic [15:0] count_b;
        logic chan_end;
        logic [1:0] idx;
        logic [31:0] data;
        logic req;
        logic we;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic done;
    } ctl_state_t;

    ctl_state_t s_q;
    ctl_state_t s_d;

    logic pick_valid;
    logic [IDX_W-1:0] pick_idx;
    logic [15:0] count_a_next;
    logic [15:0] count_b_next;
    logic unit_last;
    logic chan_end;

    ////////////////////////////////////////////////////////////////////////////////

    // Word index of an APB address; bit 3 flags a mapped word
    function automatic logic [3:0] reg_index(input logic [7:0] a);
        logic [3:0] r;
        r = 4'h0;
        if (a[1:0] == 2'h0 && a <= `OFS_STATUS) begin
            r = {1'b1, a[4:2]};
        end
        return r;
    endfunction

    function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] am,
                                              input logic [1:0] sz);
        logic [31:0] unit;
        unit = (sz == `SZ_LONG) ? 32'h0000_0004 : (sz == `SZ_WORD) ? 32'h0000_0002 :
               32'h0000_0001;
        if (am == `AM_INC) begin
            return a + unit;
        end else if (am == `AM_DEC) begin
            return a - unit;
        end
        return a;
    endfunction

    function automatic logic [31:0] info_word(input ctl_state_t s, input logic [1:0] i);
        logic [31:0] w;
        w = {s.mode_a, s.mode_b, s.count_a};
        if (i == 2'h1) begin
            w = s.src_addr;
        end else if (i == 2'h2) begin
            w = s.dst_addr;
        end else if (i == `INFO_LAST_WORD) begin
            w = {`RST_HALF, s.count_b};
        end
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    source_picker #(
        .NUM_SRC(NUM_SRC),
        .IDX_W(IDX_W)
    ) u_picker (
        .src_req(src_req),
        .src_en(s_q.enable),
        .pick_valid(pick_valid),
        .pick_idx(pick_idx),
        .cpu_irq(cpu_irq)
    );

    count_step u_count (
        .mode(s_q.mode_a[`MODE_MD_HI:`MODE_MD_LO]),
        .count_a(s_q.count_a),
        .count_b(s_q.count_b),
        .count_a_next(count_a_next),
        .count_b_next(count_b_next),
        .unit_last(unit_last),
        .chan_end(chan_end)
    );

    ////////////////////////////////////////////////////////////////////////////////

    logic [3:0] hit;
    logic [1:0] md;
    logic [1:0] sz;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        hit = reg_index(paddr);
        md = s_q.mode_a[`MODE_MD_HI:`MODE_MD_LO];
        sz = s_q.mode_a[`MODE_SZ_HI:`MODE_SZ_LO];

        // APB setup phase captures read data; access phase commits writes
        if (psel && !penable) begin
            s_d.prdata = `RST_WORD;
            if (hit[3] && hit[2:0] < 3'(BANKS)) begin
                s_d.prdata = {`RST_HALF, s_q.enable[hit[2:0]]};
            end else if (hit[3] && hit[2:0] == `IDX_CONTROL) begin
                s_d.prdata[`CTRL_SKIP_BIT] = s_q.skip_ok;
            end else if (hit[3] && hit[2:0] == `IDX_VECTOR_BASE) begin
                s_d.prdata = s_q.vector_base;
            end else if (hit[3] && hit[2:0] == `IDX_STATUS) begin
                s_d.prdata = {16'h0000, s_q.last_valid, (s_q.st != ST_IDLE),
                              6'(s_q.last_src), 8'(s_q.src)};
            end
        end
        if (psel && penable && pwrite && hit[3]) begin
            if (hit[2:0] < 3'(BANKS)) begin
                s_d.enable[hit[2:0]] = pwdata[15:0];
            end else if (hit[2:0] == `IDX_CONTROL) begin
                s_d.skip_ok = pwdata[`CTRL_SKIP_BIT];
            end else if (hit[2:0] == `IDX_VECTOR_BASE) begin
                s_d.vector_base = pwdata;
            end
        end

        // A one-cycle acknowledge completes the outstanding memory request
        if (s_q.req && mem_ack) begin
            s_d.req = 1'b0;
        end

        unique case (s_q.st)
            ST_IDLE: begin
                if (pick_valid) begin
                    s_d.src = pick_idx;
                    s_d.req = 1'b1;
                    if (s_q.skip_ok && s_q.last_valid && pick_idx == s_q.last_src) begin
                        s_d.st = ST_DATA_RD;
                        s_d.we = 1'b0;
                        s_d.size = sz;
                        s_d.addr = s_q.src_addr;
                    end else begin
                        s_d.st = ST_VEC_RD;
                        s_d.we = 1'b0;
                        s_d.size = `SZ_LONG;
                        s_d.addr = s_q.vector_base + {23'h0, pick_idx, 2'h0};
                    end
                end
            end
            ST_VEC_RD: begin
                if (mem_ack) begin
                    s_d.info_ptr = mem_rdata;
                    s_d.idx = 2'h0;
                    s_d.st = ST_INFO_RD;
                    s_d.req = 1'b1;
                    s_d.addr = mem_rdata;
                end
            end
            ST_INFO_RD: begin
                if (mem_ack) begin
                    if (s_q.idx == 2'h0) begin
                        s_d.mode_a = mem_rdata[`INFO_MODE_A_HI:`INFO_MODE_A_LO];
                        s_d.mode_b = mem_rdata[`INFO_MODE_B_HI:`INFO_MODE_B_LO];
                        s_d.count_a = mem_rdata[15:0];
                    end else if (s_q.idx == 2'h1) begin
                        s_d.src_addr = mem_rdata;
                    end else if (s_q.idx == 2'h2) begin
                        s_d.dst_addr = mem_rdata;
                    end else begin
                        s_d.count_b = mem_rdata[15:0];
                    end
                    s_d.req = 1'b1;
                    if (s_q.idx == `INFO_LAST_WORD) begin
                        s_d.st = ST_DATA_RD;
                        s_d.size = s_q.mode_a[`MODE_SZ_HI:`MODE_SZ_LO];
                        s_d.addr = s_q.src_addr;
                    end else begin
                        s_d.idx = s_q.idx + 2'h1;
                        s_d.addr = s_q.info_ptr + {28'h0, s_q.idx + 2'h1, 2'h0};
                    end
                end
            end
            ST_DATA_RD: begin
                if (mem_ack) begin
                    s_d.data = mem_rdata;
                    s_d.st = ST_DATA_WR;
                    s_d.req = 1'b1;
                    s_d.we = 1'b1;
                    s_d.addr = s_q.dst_addr;
                    s_d.wdata = mem_rdata;
                end
            end
            ST_DATA_WR: begin
                if (mem_ack) begin
                    s_d.src_addr = step_addr(s_q.src_addr,
                                             s_q.mode_a[`MODE_SM_HI:`MODE_SM_LO], sz);
                    s_d.dst_addr = step_addr(s_q.dst_addr,
                                             s_q.mode_a[`MODE_DM_HI:`MODE_DM_LO], sz);
                    s_d.count_a = count_a_next;
                    s_d.count_b = count_b_next;
                    s_d.chan_end = chan_end;
                    s_d.req = 1'b1;
                    if (md == `MD_BLOCK && !unit_last) begin
                        s_d.st = ST_DATA_RD;
                        s_d.we = 1'b0;
                        s_d.addr = step_addr(s_q.src_addr,
                                             s_q.mode_a[`MODE_SM_HI:`MODE_SM_LO], sz);
                    end else begin
                        s_d.st = ST_WRITE_BACK;
                        s_d.idx = 2'h0;
                        s_d.size = `SZ_LONG;
                        s_d.addr = s_q.info_ptr;
                        s_d.wdata = {s_q.mode_a, s_q.mode_b, count_a_next};
                    end
                end
            end
            ST_WRITE_BACK: begin
                if (mem_ack) begin
                    if (s_q.idx == `INFO_LAST_WORD) begin
                        s_d.st = ST_IDLE;
                        s_d.we = 1'b0;
                        s_d.last_src = s_q.src;
                        s_d.last_valid = !s_q.chan_end;
                        if (s_q.chan_end) begin
                            s_d.enable[s_q.src[IDX_W-1:4]][s_q.src[3:0]] = 1'b0;
                            s_d.done = 1'b1;
                        end
                    end else begin
                        s_d.idx = s_q.idx + 2'h1;
                        s_d.req = 1'b1;
                        s_d.addr = s_q.info_ptr + {28'h0, s_q.idx + 2'h1, 2'h0};
                        s_d.wdata = info_word(s_q, s_q.idx + 2'h1);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign pready = 1'b1;
    assign pslverr = psel && penable && (!hit[3] ||
                     (hit[2:0] >= 3'(BANKS) && hit[2:0] < `IDX_CONTROL));
    assign prdata = s_q.prdata;
    assign xfer_done = s_q.done;
    assign mem_req = s_q.req;
    assign mem_we = s_q.we;
    assign mem_size = s_q.size;
    assign mem_addr = s_q.addr;
    assign mem_wdata = s_q.wdata;

endmodule

/* verif/transfer_controller_sva.sv */
`timescale 1ns/100ps
module transfer_controller_sva #(
    parameter int NUM_SRC = 80
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_SRC-1:0] src_req,
    input wire logic [NUM_SRC-1:0] cpu_irq,
    input wire logic xfer_done,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [1:0] mem_size,
    input wire logic [31:0] mem_addr,
    input wire logic mem_ack
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_wait;
        mem_req && !mem_ack;
    endsequence

    sequence s_last_wb;
        mem_req && mem_ack && mem_we;
    endsequence

    chk_req_hold: assert property (s_wait |=>
        mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request changed before ack");
    chk_size_hold: assert property (s_wait |=> $stable(mem_size) && mem_size != 2'h3)
        else $error("memory size changed or illegal");
    chk_start_read: assert property ($rose(mem_req) |-> !mem_we)
        else $error("activation did not start with a read");
    chk_done_cause: assert property (xfer_done |->
        $past(mem_req && mem_ack && mem_we) && !mem_req)
        else $error("done pulse without final write back");
    chk_done_single: assert property (s_last_wb ##1 xfer_done |=> !xfer_done [*4])
        else $error("done pulse longer than one cycle");
    chk_irq_subset: assert property ((cpu_irq & ~src_req) == '0)
        else $error("cpu request without source request");
    chk_err_unmapped: assert property (psel && penable && paddr >= 8'h20 |-> pslverr)
        else $error("unmapped access not refused");
    chk_ok_mapped: assert property (psel && penable && paddr < 8'h20 &&
        paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    chk_err_access: assert property (pslverr |-> psel && penable && pready)
        else $error("error outside access phase");
endmodule

bind transfer_controller transfer_controller_sva #(.NUM_SRC(NUM_SRC)) sva_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .src_req(src_req), .cpu_irq(cpu_irq),
    .xfer_done(xfer_done), .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size),
    .mem_addr(mem_addr), .mem_ack(mem_ack)
);

/* verif/mem_partner.sv */
`timescale 1ns/100ps
module mem_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0] lag,
    output logic [31:0] mem_rdata,
    output logic mem_ack
);
    logic [31:0] ram [0:255];
    logic [3:0] cnt;

    // Read data is only valid with ack; it holds on a write ack, loads on a read ack and otherwise toggles every cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            cnt <= 4'h0;
            mem_rdata <= 32'h5a5a_a5a5;
        end else if (mem_req && !mem_ack && cnt >= lag) begin
            mem_ack <= 1'b1;
            cnt <= 4'h0;
            if (mem_we) begin
                ram[mem_addr[9:2]] <= mem_wdata;
            end else begin
                mem_rdata <= ram[mem_addr[9:2]];
            end
        end else begin
            mem_ack <= 1'b0;
            cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

/* verif/tb_transfer_controller.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    $display("MISMATCH %s exp %h got %h", n, e, g); mismatches++; end end
module tb_transfer_controller;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic xfer_done, mem_req, mem_we, mem_ack;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rd;
    logic [1:0] mem_size;
    logic [79:0] src_req, cpu_irq;
    logic [3:0] lag;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    int dones = 0;

    transfer_controller transfer_controller_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_req(src_req), .cpu_irq(cpu_irq), .xfer_done(xfer_done), .mem_req(mem_req),
        .mem_we(mem_we), .mem_size(mem_size), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack)
    );

    mem_partner mem_partner_inst (
        .pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lag(lag), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (xfer_done === 1'b1) begin
            dones <= dones + 1;
        end
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    task give_verdict();
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task ram_w(input int a, input logic [31:0] d);
        mem_partner_inst.ram[a[9:2]] = d;
    endtask

    function automatic logic [31:0] mw(input int a);
        return mem_partner_inst.ram[a[9:2]];
    endfunction

    task chan(input int src, input int ptr, input logic [31:0] w0, input int sa, input int da,
              input logic [31:0] cb);
        ram_w(32'h100 + 4 * src, ptr);
        ram_w(ptr, w0);
        ram_w(ptr + 4, sa);
        ram_w(ptr + 8, da);
        ram_w(ptr + 12, cb);
    endtask

    // Request held until the controller starts, then dropped so it fires once
    task fire(input int src);
        @(posedge pclk);
        src_req[src] <= 1'b1;
        do @(posedge pclk); while (mem_req !== 1'b1);
        src_req[src] <= 1'b0;
        do @(posedge pclk); while (mem_req !== 1'b0);
        repeat (3) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        src_req = '0;
        lag = 4'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        `CHK("bank_a_rst", 32'h0, rd)
        apb(1'b1, 8'h00, 32'hffff_ffff);
        apb(1'b0, 8'h00, 32'h0);
        `CHK("bank_a", 32'h0000_ffff, rd)
        apb(1'b1, 8'h18, 32'h0000_0100);
        apb(1'b0, 8'h18, 32'h0);
        `CHK("vec_base", 32'h0000_0100, rd)
        apb(1'b1, 8'h14, 32'h0000_0010);
        apb(1'b0, 8'h14, 32'h0);
        `CHK("control", 32'h0000_0010, rd)
        apb(1'b1, 8'h14, 32'h0);
        apb(1'b1, 8'h20, 32'h0);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, 8'h1c, 32'hffff_ffff);
        `CHK("status_wr", 1'b0, err)
        apb(1'b1, 8'h10, 32'h0000_0001);
        apb(1'b1, 8'h00, 32'h0000_0038);
        ram_w(32'h340, 32'h1111_0001);
        ram_w(32'h344, 32'h2222_0002);
        chan(3, 32'h280, {8'h24, 8'h00, 16'h0002}, 32'h340, 32'h380, 32'h0000_beef);
        fire(3);
        `CHK("n_cnt1", {8'h24, 8'h00, 16'h0001}, mw(32'h280))
        `CHK("n_dst1", 32'h1111_0001, mw(32'h380))
        `CHK("n_run", 0, dones)
        fire(3);
        `CHK("n_cnt0", {8'h24, 8'h00, 16'h0000}, mw(32'h280))
        `CHK("n_src", 32'h0000_0348, mw(32'h284))
        `CHK("n_dst", 32'h0000_0380, mw(32'h288))
        `CHK("n_dst2", 32'h2222_0002, mw(32'h380))
        `CHK("n_cntb", 16'hbeef, mw(32'h28c) & 32'h0000_ffff)
        `CHK("n_done", 1, dones)
        apb(1'b0, 8'h00, 32'h0);
        `CHK("n_en_clr", 32'h0000_0030, rd)
        src_req[3] <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK("n_irq", 1'b1, cpu_irq[3])
        `CHK("n_idle", 1'b0, mem_req)
        src_req[3] <= 1'b0;
        chan(4, 32'h290, {8'h24, 8'h00, 16'h0000}, 32'h340, 32'h384, 32'h0);
        fire(4);
        `CHK("z_cnt", {8'h24, 8'h00, 16'hffff}, mw(32'h290))
        `CHK("z_run", 1, dones)
        lag <= 4'h2;
        chan(5, 32'h2a0, {8'h64, 8'h00, 16'h0201}, 32'h340, 32'h388, 32'h0);
        fire(5);
        `CHK("r_cnt", {8'h64, 8'h00, 16'h0202}, mw(32'h2a0))
        `CHK("r_dst", 32'h1111_0001, mw(32'h388))
        `CHK("r_run", 1, dones)
        lag <= 4'h3;
        chan(64, 32'h2b0, {8'ha5, 8'h00, 16'h0202}, 32'h340, 32'h390, 32'h0000_0001);
        fire(64);
        `CHK("b_cnt", {8'ha5, 8'h00, 16'h0202}, mw(32'h2b0))
        `CHK("b_cntb", 32'h0, mw(32'h2bc) & 32'h0000_ffff)
        `CHK("b_d0", 32'h1111_0001, mw(32'h390))
        `CHK("b_d1", 32'h2222_0002, mw(32'h394))
        `CHK("b_src", 32'h0000_0348, mw(32'h2b4))
        `CHK("b_done", 2, dones)
        apb(1'b0, 8'h10, 32'h0);
        `CHK("b_en_clr", 32'h0, rd)
        // Second activation of the same source must reuse the cached information
        apb(1'b1, 8'h14, 32'h0000_0010);
        ram_w(32'h348, 32'h3333_0003);
        fire(5);
        ram_w(32'h2a0, {8'h64, 8'h00, 16'h0205});
        fire(5);
        `CHK("s_cnt", {8'h64, 8'h00, 16'h0202}, mw(32'h2a0))
        `CHK("s_src", 32'h0000_034c, mw(32'h2a4))
        `CHK("s_dst", 32'h3333_0003, mw(32'h388))
        `CHK("s_run", 2, dones)
        apb(1'b0, 8'h1c, 32'h0);
        `CHK("status", 32'h0000_8505, rd)
        give_verdict();
    end
endmodule
